// >>> shared/mute_ramp_defs.vh
// constants and state encodings for the mute ramp and power limiter
`ifndef MUTE_RAMP_DEFS_VH
`define MUTE_RAMP_DEFS_VH

// clock rate
`define CLK_MHZ          100
// selectable mute times in microseconds (field values 0..3)
`define TMUTE0_US        1280
`define TMUTE1_US        2560
`define TMUTE2_US        5120
`define TMUTE3_US        10240
// ramp gain resolution: unity gain equals 128 steps
`define GAIN_W           8
`define GAIN_UNITY       8'h80
`define GAIN_SHIFT       7
`define STEP_CNT_W       24
// field positions
`define MUTE_TIME_HI     7
`define MUTE_TIME_LO     6
`define LIM_CODE_HI      3
`define LIM_CODE_LO      0
`define STATUS_SAM_BIT   4
// limiter threshold scale: percent times this gives full-scale fraction
`define LIM_PCT_SCALE    17'h00148
`define FULL_SCALE       17'h07fff
// ramp states
`define ST_PLAY          2'h0
`define ST_RAMP_DN       2'h1
`define ST_MUTED         2'h2
`define ST_RAMP_UP       2'h3
// audio sample and fifo shape
`define SAMPLE_W         16
`define FIFO_DEPTH       8
`define FIFO_AW          3

`endif

// >>> hw/mute_ramp_and_power_limit.v
// mute arbitration, digital mute ramp, power limiter and sample fifo
`timescale 1ns/100ps
`include "mute_ramp_defs.vh"

// sample fifo with valid/ready on both sides
module sample_fifo #(
    parameter WIDTH = `SAMPLE_W,
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW    = `FIFO_AW
) (
    input  wire             i_mclk,
    input  wire             i_rstn,
    input  wire [WIDTH-1:0] i_wr_data,
    input  wire             i_wr_valid,
    output wire             o_wr_ready,
    output wire [WIDTH-1:0] o_rd_data,
    output wire             o_rd_valid,
    input  wire             i_rd_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_r;
    reg [AW:0]      rd_ptr_r;
    reg             wr_ready_r;
    wire [AW:0]     wr_ptr_nxt;
    wire [AW:0]     rd_ptr_nxt;
    wire            full;
    wire            empty;
    wire            do_wr;
    wire            do_rd;

    // pointers carry one extra wrap bit to tell full from empty
    assign empty      = (wr_ptr_r == rd_ptr_r);
    assign full       = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) &&
                        (wr_ptr_r[AW] != rd_ptr_r[AW]);
    assign o_wr_ready = wr_ready_r;
    assign o_rd_valid = ~empty;
    assign o_rd_data  = mem[rd_ptr_r[AW-1:0]];
    assign do_wr      = i_wr_valid & ~full;
    assign do_rd      = i_rd_ready & ~empty;
    // next pointers, so the registered ready sees the coming fill level
    assign wr_ptr_nxt = do_wr ? wr_ptr_r + {{AW{1'b0}}, 1'b1} : wr_ptr_r;
    assign rd_ptr_nxt = do_rd ? rd_ptr_r + {{AW{1'b0}}, 1'b1} : rd_ptr_r;

    // storage write
    always @(posedge i_mclk) begin
        if (do_wr) begin
            mem[wr_ptr_r[AW-1:0]] <= i_wr_data;
        end
    end

    // pointer update
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            wr_ptr_r <= {(AW+1){1'b0}};
            rd_ptr_r <= {(AW+1){1'b0}};
            wr_ready_r <= 1'b1;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            wr_ready_r <= ~((wr_ptr_nxt[AW-1:0] == rd_ptr_nxt[AW-1:0]) &&
                            (wr_ptr_nxt[AW] != rd_ptr_nxt[AW]));
        end
    end
endmodule // sample_fifo

// top: mute control and audio processing
module mute_ramp_and_power_limit #(
    parameter TMUTE0_CYC = `TMUTE0_US * `CLK_MHZ,
    parameter TMUTE1_CYC = `TMUTE1_US * `CLK_MHZ,
    parameter TMUTE2_CYC = `TMUTE2_US * `CLK_MHZ,
    parameter TMUTE3_CYC = `TMUTE3_US * `CLK_MHZ
) (
    input  wire                 i_mclk,
    input  wire                 i_rstn,
    input  wire                 i_lowbatt_win,
    input  wire                 i_highvolt_win,
    input  wire                 i_thermal_win,
    input  wire                 i_pin_mute_request_n,
    input  wire [7:0]           i_window_level,
    input  wire                 i_i2c_mute,
    input  wire                 i_digital_mute_disable,
    input  wire [7:0]           i_mute_time_config_byte,
    input  wire [7:0]           i_limiter_config_byte,
    input  wire                 i_limiter_wr,
    input  wire                 i_channel_in_mute,
    input  wire                 i_status_rd,
    input  wire [`SAMPLE_W-1:0] i_audio_data,
    input  wire                 i_audio_valid,
    output wire                 o_audio_ready,
    output reg  [`SAMPLE_W-1:0] o_audio_data,
    output reg                  o_audio_valid,
    input  wire                 i_audio_ready,
    output reg  [7:0]           o_analog_atten,
    output reg  [7:0]           o_mute_status_byte,
    output reg  [3:0]           o_limiter_code,
    output reg                  o_ramp_busy
);
    localparam [`STEP_CNT_W-1:0] STEP0 = TMUTE0_CYC / 128;
    localparam [`STEP_CNT_W-1:0] STEP1 = TMUTE1_CYC / 128;
    localparam [`STEP_CNT_W-1:0] STEP2 = TMUTE2_CYC / 128;
    localparam [`STEP_CNT_W-1:0] STEP3 = TMUTE3_CYC / 128;

    // limiter percent of full scale per code
    function [6:0] lim_pct;
        input [3:0] code;
        begin
            case (code)
                4'h0:    lim_pct = 7'h64; // 100, threshold clamped to full scale
                4'hb:    lim_pct = 7'h50; // 80
                4'ha:    lim_pct = 7'h46; // 70
                4'h9:    lim_pct = 7'h3c; // 60
                4'h8:    lim_pct = 7'h32; // 50
                default: lim_pct = {3'h0, code} * 7'h05 + 7'h0a;
            endcase
        end
    endfunction

    // magnitude of a signed sample, saturated to 15 bits
    function [16:0] mag;
        input [`SAMPLE_W-1:0] s;
        begin
            if (s[`SAMPLE_W-1]) begin
                mag = {1'b0, (~s) + 16'h0001};
            end else begin
                mag = {1'b0, s};
            end
            if (mag > `FULL_SCALE) begin
                mag = `FULL_SCALE;
            end
        end
    endfunction

    // pin and comparator inputs, two-stage synchronisers
    reg  [3:0]  sync1_r;
    reg  [3:0]  sync2_r;
    reg  [7:0]  lvl1_r;
    reg  [7:0]  lvl2_r;
    wire        lowbatt;
    wire        highvolt;
    wire        thermal;
    wire        pin_mute;
    wire        sam_now;

    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            sync1_r <= 4'h8; // pin idles high: play
            sync2_r <= 4'h8;
            lvl1_r  <= 8'h00;
            lvl2_r  <= 8'h00;
        end else begin
            sync1_r <= {i_pin_mute_request_n, i_thermal_win,
                        i_highvolt_win, i_lowbatt_win};
            sync2_r <= sync1_r;
            lvl1_r  <= i_window_level;
            lvl2_r  <= lvl1_r;
        end
    end

    // low pin level requests mute
    assign lowbatt  = sync2_r[0];
    assign highvolt = sync2_r[1];
    assign thermal  = sync2_r[2];
    assign pin_mute = ~sync2_r[3];
    // mixed-mute sources raise the start-analog-mute signal
    assign sam_now  = lowbatt | highvolt | pin_mute;

    // analog attenuation tracks the level while an analog source is active
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_analog_atten <= 8'h00;
        end else if (thermal | sam_now) begin
            o_analog_atten <= lvl2_r;
        end else begin
            o_analog_atten <= 8'h00;
        end
    end

    // ramp state machine and start-analog-mute tracking
    reg  [1:0]             state_r;
    reg  [1:0]             state_nxt;
    reg                    sam_acc_r;
    reg                    sam_flag_r;
    reg  [`GAIN_W-1:0]     gain_r;
    reg  [`STEP_CNT_W-1:0] step_cnt_r;
    reg  [`STEP_CNT_W-1:0] step_len;
    wire                   stable;
    wire                   want_mute;
    wire                   step_tick;
    wire [1:0]             tsel;

    assign tsel      = i_mute_time_config_byte[`MUTE_TIME_HI:`MUTE_TIME_LO];
    assign stable    = (state_r == `ST_PLAY) || (state_r == `ST_MUTED);
    // disable bit removes mixed sources from the digital path; i2c stays
    assign want_mute = (sam_acc_r & ~i_digital_mute_disable)
                       | i_i2c_mute;
    // at or past the step length, so a shorter time picked mid-ramp cannot stall
    assign step_tick = (step_cnt_r >= step_len);

    // step length from the selected mute time
    always @* begin
        case (tsel)
            2'h0:    step_len = STEP0;
            2'h1:    step_len = STEP1;
            2'h2:    step_len = STEP2;
            default: step_len = STEP3;
        endcase
    end

    // next ramp state
    always @* begin
        state_nxt = state_r;
        case (state_r)
            `ST_PLAY: begin
                if (want_mute) begin
                    state_nxt = `ST_RAMP_DN;
                end
            end
            `ST_RAMP_DN: begin
                if (step_tick && gain_r == 8'h01) begin
                    state_nxt = `ST_MUTED;
                end
            end
            `ST_MUTED: begin
                if (!want_mute) begin
                    state_nxt = `ST_RAMP_UP;
                end
            end
            `ST_RAMP_UP: begin
                if (step_tick && gain_r == `GAIN_UNITY - 8'h01) begin
                    state_nxt = `ST_PLAY;
                end
            end
            default: state_nxt = `ST_PLAY;
        endcase
    end

    // state, gain ramp and step timer
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            state_r    <= `ST_PLAY;
            gain_r     <= `GAIN_UNITY;
            step_cnt_r <= {`STEP_CNT_W{1'b0}};
            o_ramp_busy <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            o_ramp_busy <= (state_nxt == `ST_RAMP_DN) ||
                           (state_nxt == `ST_RAMP_UP);
            if (state_r == `ST_RAMP_DN || state_r == `ST_RAMP_UP) begin
                if (step_tick) begin
                    step_cnt_r <= {`STEP_CNT_W{1'b0}};
                    if (state_r == `ST_RAMP_DN) begin
                        gain_r <= gain_r - 8'h01;
                    end else begin
                        gain_r <= gain_r + 8'h01;
                    end
                end else begin
                    step_cnt_r <= step_cnt_r + 24'h000001;
                end
            end else begin
                step_cnt_r <= {`STEP_CNT_W{1'b0}};
            end
        end
    end

    // start-analog-mute is sampled only outside a ramp; set beats read clear
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            sam_acc_r  <= 1'b0;
            sam_flag_r <= 1'b0;
        end else if (stable && sam_now != sam_acc_r) begin
            sam_acc_r  <= sam_now;
            sam_flag_r <= sam_now;
        end else if (i_status_rd) begin
            sam_flag_r <= 1'b0;
        end
    end

    // status byte register
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_mute_status_byte <= 8'h00;
        end else begin
            o_mute_status_byte <= {3'h0, sam_flag_r, 4'h0};
        end
    end

    // limiter code: taken only while the channel sits in mute
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_limiter_code <= 4'h0;
        end else if (i_limiter_wr && i_channel_in_mute) begin
            o_limiter_code <=
                i_limiter_config_byte[`LIM_CODE_HI:`LIM_CODE_LO];
        end
    end

    // sample fifo in front of the processing stage
    wire [`SAMPLE_W-1:0] f_data;
    wire                 f_valid;
    wire                 f_ready;

    assign f_ready = ~o_audio_valid | i_audio_ready;

    sample_fifo #(
        .WIDTH (`SAMPLE_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .i_mclk     (i_mclk),
        .i_rstn     (i_rstn),
        .i_wr_data  (i_audio_data),
        .i_wr_valid (i_audio_valid),
        .o_wr_ready (o_audio_ready),
        .o_rd_data  (f_data),
        .o_rd_valid (f_valid),
        .i_rd_ready (f_ready)
    );

    // digital gain then soft limiter on the sample magnitude
    reg  [16:0] m_in;
    reg  [24:0] prod;
    reg  [16:0] m_g;
    reg  [16:0] thr;
    reg  [16:0] knee;
    reg  [16:0] m_out;
    reg  [15:0] s_out;

    always @* begin
        m_in  = mag(f_data);
        prod  = m_in * {9'h000, gain_r};
        m_g   = prod[16+`GAIN_SHIFT:`GAIN_SHIFT];
        thr   = {10'h000, lim_pct(o_limiter_code)} * `LIM_PCT_SCALE;
        if (thr > `FULL_SCALE) begin
            thr = `FULL_SCALE;
        end
        knee  = thr >> 1;
        // above the knee slope halves, then holds at the threshold
        if (m_g <= knee) begin
            m_out = m_g;
        end else if (knee + ((m_g - knee) >> 1) < thr) begin
            m_out = knee + ((m_g - knee) >> 1);
        end else begin
            m_out = thr;
        end
        // sign restored on the scaled input sample
        if (f_data[`SAMPLE_W-1]) begin
            s_out = (~m_out[15:0]) + 16'h0001;
        end else begin
            s_out = m_out[15:0];
        end
    end

    // output register stage
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_audio_data  <= {`SAMPLE_W{1'b0}};
            o_audio_valid <= 1'b0;
        end else if (f_ready) begin
            o_audio_valid <= f_valid;
            if (f_valid) begin
                o_audio_data <= s_out;
            end
        end
    end
endmodule // mute_ramp_and_power_limit

// >>> tb/mute_ramp_properties.sv
// assertions on the mute ramp and limiter ports
`timescale 1ns/100ps
module mute_ramp_properties #(
    parameter TMUTE0_CYC = 1280,
    parameter TMUTE1_CYC = 2560,
    parameter TMUTE2_CYC = 5120,
    parameter TMUTE3_CYC = 10240
) (
    input wire       i_mclk,
    input wire       i_rstn,
    input wire       i_lowbatt_win,
    input wire       i_highvolt_win,
    input wire       i_thermal_win,
    input wire       i_pin_mute_request_n,
    input wire [7:0] i_window_level,
    input wire [7:0] i_mute_time_config_byte,
    input wire [7:0] i_limiter_config_byte,
    input wire       i_limiter_wr,
    input wire       i_channel_in_mute,
    input wire       i_status_rd,
    input wire [7:0] o_analog_atten,
    input wire [7:0] o_mute_status_byte,
    input wire [3:0] o_limiter_code,
    input wire       o_ramp_busy
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    // source summary, flag, limiter field and expected ramp length
    wire        quiet = !i_lowbatt_win && !i_highvolt_win &&
                        i_pin_mute_request_n;
    wire        flag = o_mute_status_byte[4];
    wire [3:0]  lim_in = i_limiter_config_byte[3:0];
    wire [1:0]  ts = i_mute_time_config_byte[7:6];
    wire [31:0] rl = ((ts == 2'h0 ? TMUTE0_CYC : ts == 2'h1 ? TMUTE1_CYC :
                       ts == 2'h2 ? TMUTE2_CYC : TMUTE3_CYC) / 128 + 1) * 128;
    integer     cnt_r;
    // counts busy cycles of the running ramp
    always @(posedge i_mclk) begin
        if (!i_rstn || !o_ramp_busy) cnt_r <= 0;
        else cnt_r <= cnt_r + 1;
    end
    a_ramp_length: assert property (
        $fell(o_ramp_busy) |-> cnt_r >= rl - 4 && cnt_r <= rl + 4)
        else $error("ramp length wrong");
    a_pin_flag: assert property (
        $fell(i_pin_mute_request_n) && !o_ramp_busy && !i_lowbatt_win &&
        !i_highvolt_win |-> ##[1:6] flag) else $error("no start flag");
    a_flag_only: assert property (
        o_mute_status_byte[7:5] == 3'h0 && o_mute_status_byte[3:0] == 4'h0)
        else $error("spare status bits set");
    a_read_clear: assert property (
        (!o_ramp_busy && !i_pin_mute_request_n)[*6] ##0 i_status_rd |->
        ##2 !flag)
        else $error("read kept flag");
    a_quiet_noflag: assert property (
        quiet[*5] |-> !$rose(flag)) else $error("flag without source");
    a_lim_take: assert property (
        i_limiter_wr && i_channel_in_mute |=> o_limiter_code == $past(lim_in))
        else $error("limiter code not taken");
    a_lim_hold: assert property (
        i_limiter_wr && !i_channel_in_mute |=> $stable(o_limiter_code))
        else $error("limiter code changed");
    a_atten_zero: assert property (
        (quiet && !i_thermal_win)[*5] |-> o_analog_atten == 8'h00)
        else $error("attenuation without source");
    a_atten_level: assert property (
        (i_thermal_win && $stable(i_window_level))[*5] |->
        o_analog_atten == i_window_level) else $error("attenuation off");
    c_ramp: cover property ($rose(o_ramp_busy));
    c_flag_clear: cover property ($fell(flag));
    c_lim_wr: cover property (i_limiter_wr && i_channel_in_mute);
endmodule // mute_ramp_properties

// >>> tb/host_model.sv
// host model: writes the amplifier settings and reads its status
`timescale 1ns/100ps
module host_model (
    input  wire       i_mclk,
    output reg  [7:0] o_limiter_config_byte = 8'h00,
    output reg        o_limiter_wr = 1'b0,
    output reg        o_channel_in_mute = 1'b0,
    output reg        o_status_rd = 1'b0,
    output reg        o_i2c_mute = 1'b0,
    output reg        o_digital_mute_disable = 1'b0,
    output reg  [7:0] o_mute_time_config_byte = 8'h00
);
    // one-cycle threshold write, normally issued in mute state
    task wr_limiter(input [3:0] code, input in_mute);
        @(negedge i_mclk);
        o_channel_in_mute = in_mute;
        o_limiter_config_byte = {4'h0, code};
        o_limiter_wr = 1'b1;
        @(negedge i_mclk);
        o_limiter_wr = 1'b0;
        o_channel_in_mute = 1'b0;
    endtask
    // one-cycle status read, clears a stale start flag
    task rd_status;
        @(negedge i_mclk);
        o_status_rd = 1'b1;
        @(negedge i_mclk);
        o_status_rd = 1'b0;
    endtask
    // mute command, digital mute disable and mute time field
    task set_cfg(input i2c, input dis, input [1:0] tm);
        @(negedge i_mclk);
        o_i2c_mute = i2c;
        o_digital_mute_disable = dis;
        o_mute_time_config_byte = {tm, 6'h00};
    endtask
endmodule // host_model

// >>> tb/mute_ramp_and_power_limit_tb.sv
// bench: limiter codes, fifo, mute sources and status flag
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked = samples_checked + 1; \
    if ((g) !== (e)) begin failures = failures + 1; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module mute_ramp_and_power_limit_tb;
    reg         i_mclk = 1'b0;
    reg         i_rstn = 1'b0;
    reg         i_lowbatt_win = 1'b0;
    reg         i_highvolt_win = 1'b0;
    reg         i_thermal_win = 1'b0;
    reg         i_pin_mute_request_n = 1'b1;
    reg  [7:0]  i_window_level = 8'h5a;
    reg  [15:0] i_audio_data = 16'h0000;
    reg         i_audio_valid = 1'b0;
    reg         i_audio_ready = 1'b0;
    reg  [3:0]  c;
    wire [7:0]  i_mute_time_config_byte, i_limiter_config_byte;
    wire        i_limiter_wr, i_channel_in_mute, i_status_rd;
    wire        i_i2c_mute, i_digital_mute_disable;
    wire        o_audio_ready, o_audio_valid, o_ramp_busy;
    wire [15:0] o_audio_data;
    wire [7:0]  o_analog_atten, o_mute_status_byte;
    wire [3:0]  o_limiter_code;
    integer     failures = 0;
    integer     samples_checked = 0;
    integer     cycles = 0;
    integer     i, n;
    // clock, then the two instances
    always #5 i_mclk = ~i_mclk;
    mute_ramp_and_power_limit #(.TMUTE0_CYC(1280), .TMUTE1_CYC(2560),
        .TMUTE2_CYC(5120), .TMUTE3_CYC(10240))
        u_mute_ramp_and_power_limit (.i_mclk(i_mclk), .i_rstn(i_rstn),
        .i_lowbatt_win(i_lowbatt_win), .i_highvolt_win(i_highvolt_win),
        .i_thermal_win(i_thermal_win),
        .i_pin_mute_request_n(i_pin_mute_request_n),
        .i_window_level(i_window_level), .i_i2c_mute(i_i2c_mute),
        .i_digital_mute_disable(i_digital_mute_disable),
        .i_mute_time_config_byte(i_mute_time_config_byte),
        .i_limiter_config_byte(i_limiter_config_byte),
        .i_limiter_wr(i_limiter_wr), .i_channel_in_mute(i_channel_in_mute),
        .i_status_rd(i_status_rd), .i_audio_data(i_audio_data),
        .i_audio_valid(i_audio_valid), .o_audio_ready(o_audio_ready),
        .o_audio_data(o_audio_data), .o_audio_valid(o_audio_valid),
        .i_audio_ready(i_audio_ready), .o_analog_atten(o_analog_atten),
        .o_mute_status_byte(o_mute_status_byte),
        .o_limiter_code(o_limiter_code), .o_ramp_busy(o_ramp_busy));
    host_model u_host_model (.i_mclk(i_mclk),
        .o_limiter_config_byte(i_limiter_config_byte),
        .o_limiter_wr(i_limiter_wr), .o_channel_in_mute(i_channel_in_mute),
        .o_status_rd(i_status_rd), .o_i2c_mute(i_i2c_mute),
        .o_digital_mute_disable(i_digital_mute_disable),
        .o_mute_time_config_byte(i_mute_time_config_byte));
    // verdict and end of run
    task end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard
    always @(posedge i_mclk) begin
        cycles = cycles + 1;
        if (cycles == 80000) begin
            failures = failures + 1;
            end_of_test;
        end
    end
    // expected limiter output at unity gain
    function [15:0] lim_exp(input [3:0] cd, input [15:0] x);
        integer p, t, v;
        begin
            p = (cd == 4'h0) ? 100 : (cd >= 4'h8) ? cd * 10 - 30 : cd * 5 + 10;
            t = (p * 328 > 32767) ? 32767 : p * 328;
            v = $signed(x);
            if (v < 0) v = -v;
            if (v > t / 2) v = t / 2 + (v - t / 2) / 2;
            if (v > t) v = t;
            lim_exp = x[15] ? 16'(-v) : 16'(v);
        end
    endfunction
    // stream one sample in, then take one out and compare
    task xfer(input [15:0] x, input [15:0] e);
        @(negedge i_mclk);
        i_audio_data = x;
        i_audio_valid = 1'b1;
        for (n = 0; n < 99 && o_audio_ready !== 1'b1; n++) @(negedge i_mclk);
        @(negedge i_mclk);
        i_audio_valid = 1'b0;
        recv(e);
    endtask
    task recv(input [15:0] e);
        @(negedge i_mclk);
        i_audio_ready = 1'b1;
        for (n = 0; n < 99 && o_audio_valid !== 1'b1; n++) @(negedge i_mclk);
        `CHK("audio", e, o_audio_data)
        @(negedge i_mclk);
        i_audio_ready = 1'b0;
    endtask
    task wait_busy(input v);
        for (n = 0; n < 12000 && o_ramp_busy !== v; n++) @(negedge i_mclk);
        `CHK("busy", v, o_ramp_busy)
    endtask
    task set_src(input [1:0] s, input v);
        @(negedge i_mclk);
        if (s == 2'h0) i_lowbatt_win = v;
        else if (s == 2'h1) i_highvolt_win = v;
        else if (s == 2'h2) i_pin_mute_request_n = !v;
        else i_thermal_win = v;
    endtask
    // main sequence
    initial begin
        repeat (16) @(negedge i_mclk);
        i_rstn = 1'b1;
        for (i = 0; i < 12; i++) begin
            c = (i == 0) ? 4'h0 : 4'(12 - i);
            u_host_model.wr_limiter(c, 1'b1);
            `CHK("code", c, o_limiter_code)
            xfer(16'h7fff, lim_exp(c, 16'h7fff));
            xfer(16'h8001, lim_exp(c, 16'h8001));
        end
        u_host_model.wr_limiter(4'h5, 1'b0);
        `CHK("code", 4'h1, o_limiter_code)
        u_host_model.wr_limiter(4'h0, 1'b1);
        // fill with the sink stalled, then drain in order
        @(negedge i_mclk);
        i_audio_valid = 1'b1;
        for (n = 0; n < 20 && o_audio_ready === 1'b1; n++) begin
            i_audio_data = 16'(n);
            @(negedge i_mclk);
        end
        i_audio_valid = 1'b0;
        `CHK("fill", 9, n)
        for (i = 0; i < 9; i++) recv(16'(i));
        // each mixed source in turn, each with its own mute time
        for (i = 0; i < 3; i++) begin
            u_host_model.set_cfg(1'b0, 1'b0, 2'(i));
            set_src(2'(i), 1'b1);
            wait_busy(1'b1);
            `CHK("flag", 1'b1, o_mute_status_byte[4])
            wait_busy(1'b0);
            `CHK("atten", 8'h5a, o_analog_atten)
            xfer(16'h1234, 16'h0000);
            set_src(2'(i), 1'b0);
            wait_busy(1'b1);
            `CHK("flag", 1'b0, o_mute_status_byte[4])
            wait_busy(1'b0);
            xfer(16'h1234, 16'h1234);
        end
        u_host_model.set_cfg(1'b0, 1'b0, 2'h0);
        // read clears the flag, then pin changes during ramps
        set_src(2'h2, 1'b1);
        wait_busy(1'b1);
        wait_busy(1'b0);
        u_host_model.rd_status;
        @(negedge i_mclk);
        `CHK("flag", 1'b0, o_mute_status_byte[4])
        set_src(2'h2, 1'b0);
        wait_busy(1'b1);
        set_src(2'h2, 1'b1);
        repeat (20) @(negedge i_mclk);
        `CHK("flag", 1'b0, o_mute_status_byte[4])
        wait_busy(1'b0);
        wait_busy(1'b1);
        `CHK("flag", 1'b1, o_mute_status_byte[4])
        set_src(2'h2, 1'b0);
        wait_busy(1'b0);
        repeat (5) @(negedge i_mclk);
        wait_busy(1'b0);
        `CHK("flag", 1'b0, o_mute_status_byte[4])
        // thermal source: analog only, tracks the level
        set_src(2'h3, 1'b1);
        repeat (8) @(negedge i_mclk);
        `CHK("busy", 1'b0, o_ramp_busy)
        i_window_level = 8'h21;
        repeat (8) @(negedge i_mclk);
        `CHK("atten", 8'h21, o_analog_atten)
        set_src(2'h3, 1'b0);
        // digital mute disabled: pin mute stays analog
        u_host_model.set_cfg(1'b0, 1'b1, 2'h0);
        set_src(2'h2, 1'b1);
        repeat (8) @(negedge i_mclk);
        `CHK("busy", 1'b0, o_ramp_busy)
        xfer(16'h1234, 16'h1234);
        set_src(2'h2, 1'b0);
        repeat (8) @(negedge i_mclk);
        // i2c mute: digital only, longest mute time
        u_host_model.set_cfg(1'b1, 1'b0, 2'h3);
        wait_busy(1'b1);
        `CHK("flag", 1'b0, o_mute_status_byte[4])
        wait_busy(1'b0);
        `CHK("atten", 8'h00, o_analog_atten)
        xfer(16'h1234, 16'h0000);
        u_host_model.set_cfg(1'b0, 1'b0, 2'h3);
        wait_busy(1'b1);
        wait_busy(1'b0);
        xfer(16'h1234, 16'h1234);
        end_of_test;
    end
endmodule // mute_ramp_and_power_limit_tb
bind mute_ramp_and_power_limit mute_ramp_properties #(
    .TMUTE0_CYC(TMUTE0_CYC), .TMUTE1_CYC(TMUTE1_CYC),
    .TMUTE2_CYC(TMUTE2_CYC), .TMUTE3_CYC(TMUTE3_CYC)
) u_mute_ramp_properties (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_lowbatt_win(i_lowbatt_win), .i_highvolt_win(i_highvolt_win),
    .i_thermal_win(i_thermal_win),
    .i_pin_mute_request_n(i_pin_mute_request_n),
    .i_window_level(i_window_level),
    .i_mute_time_config_byte(i_mute_time_config_byte),
    .i_limiter_config_byte(i_limiter_config_byte),
    .i_limiter_wr(i_limiter_wr), .i_channel_in_mute(i_channel_in_mute),
    .i_status_rd(i_status_rd), .o_analog_atten(o_analog_atten),
    .o_mute_status_byte(o_mute_status_byte),
    .o_limiter_code(o_limiter_code), .o_ramp_busy(o_ramp_busy));
